// ===== lri_pkg.sv
// Purpose: Constants for the LCD driver reset and initialization block.
// Assumes: APB register access, 32-bit data, one word per register.
// Notes:   Offsets are byte addresses of a register map chosen for APB.
`default_nettype none
package lri_pkg;
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DISP   = 8'h08;
    localparam logic [7:0] REG_POWER  = 8'h0C;
    localparam logic [7:0] REG_DRIVE  = 8'h10;
    localparam logic [7:0] REG_ADDR   = 8'h14;
    localparam logic [7:0] REG_SERIAL = 8'h18;

    localparam int CMD_SOFT_RESET = 0;
    localparam int CMD_WAKE       = 1;

    localparam int ST_BUSY  = 7;
    localparam int ST_SEG   = 6;
    localparam int ST_OFF   = 5;
    localparam int ST_RESET = 4;

    localparam logic [2:0] POWER_RST    = 3'h0;
    localparam logic       BIAS_NINTH   = 1'b0;
    localparam logic [3:0] NLINE_RST    = 4'h0;
    localparam logic [1:0] STATIC_RST   = 2'h0;
    localparam logic [5:0] CONTRAST_RST = 6'h20;
    localparam logic [2:0] RATIO_RST    = 3'h0;
    localparam logic [5:0] LINE_RST     = 6'h00;
    localparam logic [7:0] COL_RST      = 8'h00;
    localparam logic [3:0] PAGE_RST     = 4'h0;

    localparam int INIT_NS     = 400;
    localparam int CLK_NS      = 40;
    localparam int INIT_CYCLES = (INIT_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// ===== lri_top.sv
// Purpose: Reset and initialization of a matrix LCD driver's settings.
// Assumes: APB slave on pclk; hardware_clear_input_n is an async pin.
// Notes:   Every output is registered; settings also readable over APB.
// Notes on behaviour
// - Hardware reset turns display off, non-inverted, segment map normal.
// - Hardware reset clears all three power control bits.
// - Hardware reset clears the serial interface shift register and count.
// - Hardware reset selects one-ninth bias.
// - Reset cancels n-line reversal drive and clears its line count.
// - Hardware reset clears power save, all-lit override, stops oscillator.
// - Reset turns static indicator off and clears its two bits.
// - Reset exits read-modify-write and test mode.
// - Reset zeroes display start line, column and page pointers.
// - Reset restores normal common scan direction.
// - Reset clears the three-bit divider ratio setting.
// - Reset cancels contrast set mode and loads contrast midpoint.
// - Software reset applies only the n-line item and static indicator through contrast items.
// - Hardware reset discharges drive voltages; host applies no external supply.
// - Status bit four reads one while any reset initialization runs.
// - Busy reads one during reset; commands are refused meanwhile.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lri_top #(
    parameter int INIT_CYCLES = lri_pkg::INIT_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        hardware_clear_input_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             display_on,
    output logic             display_inverse,
    output logic             segment_reverse,
    output logic [2:0]       power_control,
    output logic             bias_seventh,
    output logic             oscillator_run,
    output logic             discharge_drive,
    output logic             resetting
);
    // The counter is eight bits wide, which bounds the initialization time.
    initial begin
        if (INIT_CYCLES < 1 || INIT_CYCLES > 255) begin
            $error("INIT_CYCLES out of range");
        end
    end

    typedef enum logic [1:0] {ST_IDLE, ST_INIT} lri_state_t;

    typedef struct packed {
        lri_state_t  state;
        logic [7:0]  cnt;
        logic        disp_on;
        logic        inverse;
        logic        seg_rev;
        logic [2:0]  power;
        logic [7:0]  ser_shift;
        logic [2:0]  ser_count;
        logic        bias7;
        logic        nline_on;
        logic [3:0]  nline;
        logic        save;
        logic        all_lit;
        logic        osc;
        logic [1:0]  static_ind;
        logic        rmw;
        logic        test;
        logic [5:0]  line;
        logic [7:0]  col;
        logic [3:0]  page;
        logic        com_rev;
        logic [2:0]  ratio;
        logic        contrast_mode;
        logic [5:0]  contrast;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        discharge;
        logic        init_run;
    } lri_regs_t;

    lri_regs_t r_q, r_d;
    logic      sync1_q, sync2_q, hw_sync_n;

    // Assertion is immediate through the async clear; release waits two
    // edges so no setting leaves reset on a metastable edge.
    always_ff @(posedge pclk or negedge presetn or
                negedge hardware_clear_input_n) begin
        if (!presetn || !hardware_clear_input_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= 1'b1;
            sync2_q <= sync1_q;
        end
    end
    assign hw_sync_n = sync2_q;

    function automatic logic sel_is(input logic [7:0] a,
                                    input logic [7:0] off);
        sel_is = (a == off);
    endfunction

    // Items shared by both resets; software reset applies only these.
    function automatic lri_regs_t soft_items(input lri_regs_t s);
        lri_regs_t t;
        t               = s;
        t.static_ind    = lri_pkg::STATIC_RST;
        t.rmw           = 1'b0;
        t.test          = 1'b0;
        t.line          = lri_pkg::LINE_RST;
        t.col           = lri_pkg::COL_RST;
        t.page          = lri_pkg::PAGE_RST;
        t.com_rev       = 1'b0;
        t.ratio         = lri_pkg::RATIO_RST;
        t.contrast_mode = 1'b0;
        t.contrast      = lri_pkg::CONTRAST_RST;
        t.nline_on      = 1'b0;
        t.nline         = lri_pkg::NLINE_RST;
        return t;
    endfunction

    function automatic lri_regs_t hard_items(input lri_regs_t s);
        lri_regs_t t;
        t           = soft_items(s);
        t.disp_on   = 1'b0;
        t.inverse   = 1'b0;
        t.seg_rev   = 1'b0;
        t.power     = lri_pkg::POWER_RST;
        t.ser_shift = 8'h00;
        t.ser_count = 3'h0;
        t.bias7     = lri_pkg::BIAS_NINTH;
        t.save      = 1'b0;
        t.all_lit   = 1'b0;
        t.osc       = 1'b0;
        return t;
    endfunction

    logic        setup, access, wr, rd, busy;
    logic [31:0] status;

    always_comb begin
        r_d    = r_q;
        setup  = psel && !penable;
        access = psel && penable;
        // A pin reset still ripples through the synchronizer, so it counts
        // as busy before the state register has followed it.
        busy   = (r_q.state == ST_INIT) || !hw_sync_n;
        wr     = access && pwrite && r_q.ready;
        rd     = access && !pwrite && r_q.ready;
        status = 32'h0000_0000;
        status[lri_pkg::ST_BUSY]  = busy;
        status[lri_pkg::ST_SEG]   = !r_q.seg_rev;
        status[lri_pkg::ST_OFF]   = !r_q.disp_on;
        status[lri_pkg::ST_RESET] = busy;

        // Reads of mapped offsets are never refused, so software can poll busy at any time.
        // No wait states: ready rises the cycle after the setup phase.
        r_d.ready = setup;
        r_d.err   = 1'b0;

        if (setup) begin
            if (sel_is(paddr, lri_pkg::REG_CMD)) begin
                r_d.rdata = 32'h0000_0000;
            end else if (sel_is(paddr, lri_pkg::REG_STATUS)) begin
                r_d.rdata = status;
            end else if (sel_is(paddr, lri_pkg::REG_DISP)) begin
                r_d.rdata = {24'h0,
                             r_q.com_rev,
                             r_q.all_lit,
                             r_q.save,
                             r_q.rmw,
                             r_q.test,
                             r_q.seg_rev,
                             r_q.inverse,
                             r_q.disp_on};
            end else if (sel_is(paddr, lri_pkg::REG_POWER)) begin
                r_d.rdata = {18'h0,
                             r_q.contrast_mode,
                             r_q.contrast,
                             r_q.ratio,
                             r_q.osc,
                             r_q.power};
            end else if (sel_is(paddr, lri_pkg::REG_DRIVE)) begin
                r_d.rdata = {24'h0,
                             r_q.static_ind,
                             r_q.nline_on,
                             r_q.nline,
                             r_q.bias7};
            end else if (sel_is(paddr, lri_pkg::REG_ADDR)) begin
                r_d.rdata = {14'h0,
                             r_q.page,
                             r_q.col,
                             r_q.line};
            end else if (sel_is(paddr, lri_pkg::REG_SERIAL)) begin
                r_d.rdata = {21'h0,
                             r_q.ser_count,
                             r_q.ser_shift};
            end else begin
                // Unmapped offsets answer with an error rather than stall.
                r_d.rdata = 32'h0000_0000;
                r_d.err   = 1'b1;
            end
            // Writes while busy, except to the status offset, are refused with an error response.
            if (pwrite && busy && !sel_is(paddr, lri_pkg::REG_STATUS)) begin
                r_d.err = 1'b1;
            end
        end

        if (wr && !r_q.err) begin
            if (sel_is(paddr, lri_pkg::REG_CMD)) begin
                // Other command bits are reserved and ignored. A soft reset
                // leaves discharge alone; only the pin drains the supplies.
                if (pwdata[lri_pkg::CMD_SOFT_RESET]) begin
                    r_d       = soft_items(r_d);
                    r_d.state = ST_INIT;
                    r_d.cnt   = 8'(INIT_CYCLES);
                end
            end else if (sel_is(paddr, lri_pkg::REG_DISP)) begin
                {r_d.com_rev, r_d.all_lit, r_d.save, r_d.rmw, r_d.test,
                 r_d.seg_rev, r_d.inverse, r_d.disp_on} = pwdata[7:0];
            end else if (sel_is(paddr, lri_pkg::REG_POWER)) begin
                {r_d.contrast_mode, r_d.contrast, r_d.ratio, r_d.osc,
                 r_d.power} = pwdata[13:0];
            end else if (sel_is(paddr, lri_pkg::REG_DRIVE)) begin
                {r_d.static_ind, r_d.nline_on, r_d.nline, r_d.bias7} =
                    pwdata[7:0];
            end else if (sel_is(paddr, lri_pkg::REG_ADDR)) begin
                {r_d.page, r_d.col, r_d.line} = pwdata[17:0];
            end else if (sel_is(paddr, lri_pkg::REG_SERIAL)) begin
                // Serial byte shifted in MSB first; count wraps per byte.
                r_d.ser_shift = {r_q.ser_shift[6:0], pwdata[0]};
                r_d.ser_count = r_q.ser_count + 3'h1;
            end
        end

        // Countdown of the initialization time that follows either reset.
        case (r_q.state)
            ST_IDLE: begin
            end
            ST_INIT: begin
                if (r_q.cnt <= 8'h01) begin
                    r_d.state = ST_IDLE;
                end else begin
                    r_d.cnt = r_q.cnt - 8'h01;
                end
            end
            default: r_d.state = ST_IDLE;
        endcase

        // Held in full reset until the synchronized pin is released.
        if (!hw_sync_n) begin
            r_d           = hard_items(r_d);
            r_d.state     = ST_INIT;
            r_d.cnt       = 8'(INIT_CYCLES);
            r_d.discharge = 1'b1;
        end else begin
            r_d.discharge = 1'b0;
        end
        // A registered copy of the state decode keeps the flag glitch free.
        r_d.init_run = (r_d.state == ST_INIT);
    end

    // Only constants here; the pin's reset values are loaded by the
    // combinational path while the synchronizer still holds it low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q           <= '0;
            r_q.init_run  <= 1'b1;
            r_q.state     <= ST_INIT;
            r_q.cnt       <= 8'h01;
            r_q.contrast  <= lri_pkg::CONTRAST_RST;
            r_q.discharge <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign prdata          = r_q.rdata;
    assign pready          = r_q.ready;
    // The error bit is only raised in a setup cycle, so it pairs with ready.
    assign pslverr         = r_q.err;
    assign display_on      = r_q.disp_on;
    assign display_inverse = r_q.inverse;
    assign segment_reverse = r_q.seg_rev;
    assign power_control   = r_q.power;
    assign bias_seventh    = r_q.bias7;
    assign oscillator_run  = r_q.osc;
    assign discharge_drive = r_q.discharge;
    assign resetting       = r_q.init_run;
endmodule
`default_nettype wire

// ===== lri_chk.sv
// Purpose: Port checker for the LCD driver reset block.
// Assumes: Only top ports are visible; one clock domain.
// Notes:   Bound to every lri_top instance.
`timescale 1ns/1ps
`default_nettype none
module lri_chk #(
    parameter int INIT_CYCLES = 10
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        hardware_clear_input_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        display_on,
    input wire logic        display_inverse,
    input wire logic        segment_reverse,
    input wire logic [2:0]  power_control,
    input wire logic        bias_seventh,
    input wire logic        oscillator_run,
    input wire logic        discharge_drive,
    input wire logic        resetting
);
    localparam int MAXW = INIT_CYCLES + 6;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence pin_low;
        !hardware_clear_input_n ##1 !hardware_clear_input_n;
    endsequence
    sequence soft_cmd;
        psel && penable && pready && pwrite && !pslverr && pwdata[0]
            && paddr == lri_pkg::REG_CMD && hardware_clear_input_n;
    endsequence
    disp_off_a: assert property (pin_low |->
        !display_on && !display_inverse && !segment_reverse)
        else $error("display settings not cleared by pin");
    power_clr_a: assert property (pin_low |->
        power_control == 3'h0) else $error("power control not cleared");
    bias_ninth_a: assert property (pin_low |->
        !bias_seventh) else $error("bias not one ninth in reset");
    osc_stop_a: assert property (pin_low |->
        !oscillator_run) else $error("oscillator runs in reset");
    discharge_a: assert property (pin_low |->
        discharge_drive) else $error("drive not discharged in reset");
    flag_set_a: assert property (pin_low |->
        resetting) else $error("resetting low while pin held");
    soft_keep_a: assert property (soft_cmd |=>
        ($stable(display_on) && $stable(power_control)
         && $stable(bias_seventh))[*8]) else $error("soft reset hit");
    soft_busy_a: assert property (soft_cmd |->
        ##[1:2] resetting) else $error("soft reset not flagged");
    refuse_a: assert property (psel && !penable && pwrite
        && resetting && $past(resetting) && paddr != lri_pkg::REG_STATUS
        |=> pslverr) else $error("write accepted while busy");
    sync_rel_a: assert property ($rose(hardware_clear_input_n) |->
        resetting[*3] ##[1:MAXW] !resetting)
        else $error("pin release not synchronized");
    cover property (soft_cmd);
    cover property (pin_low);
    cover property (psel && penable && pready && pslverr);
endmodule
bind lri_top lri_chk #(.INIT_CYCLES(INIT_CYCLES)) chk_i (
    .pclk(pclk), .presetn(presetn),
    .hardware_clear_input_n(hardware_clear_input_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .display_on(display_on), .display_inverse(display_inverse),
    .segment_reverse(segment_reverse), .power_control(power_control),
    .bias_seventh(bias_seventh), .oscillator_run(oscillator_run),
    .discharge_drive(discharge_drive), .resetting(resetting));
`default_nettype wire

// ===== lri_host.sv
// Purpose: Host model that drives the hardware reset pin.
// Assumes: The bench asks for a pin reset through clear_req.
// Notes:   External supply is only flagged, not modelled as analog.
`timescale 1ns/1ps
`default_nettype none
module lri_host (
    input  wire logic pclk,
    input  wire logic clear_req,
    input  wire logic discharge_drive,
    output var logic  hardware_clear_input_n,
    output var logic  ext_supply_on
);
    // The pin starts low and is always driven, so it never floats.
    initial begin
        hardware_clear_input_n = 1'b0;
        ext_supply_on = 1'b0;
    end
    always @(posedge pclk) begin
        hardware_clear_input_n <= !clear_req;
        ext_supply_on <= hardware_clear_input_n && !clear_req
            && !discharge_drive;
    end
endmodule
`default_nettype wire

// ===== lri_top_test.sv
// Purpose: Self-checking bench for the LCD driver reset block.
// Assumes: The bench is the APB master; the host model owns the pin.
// Notes:   INIT_CYCLES is shortened to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module lri_top_test;
    localparam int INIT = 8;
    logic        pclk, presetn, psel, penable, pwrite, clear_req, e, ext_on;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rnd, r;
    logic        pready, pslverr, display_on, display_inverse, pin_n;
    logic        segment_reverse, bias_seventh, oscillator_run;
    logic        discharge_drive, resetting;
    logic [2:0]  power_control;
    logic [7:0]  ra [4] = '{8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] rm [4] = '{32'hFF, 32'h3FFF, 32'hFF, 32'h3FFFF};
    logic [31:0] wv [4];
    int          mismatches, check_count, cyc;
    lri_top #(.INIT_CYCLES(INIT)) uut (.pclk(pclk), .presetn(presetn),
        .hardware_clear_input_n(pin_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .display_on(display_on),
        .display_inverse(display_inverse), .segment_reverse(segment_reverse),
        .power_control(power_control), .bias_seventh(bias_seventh),
        .oscillator_run(oscillator_run), .discharge_drive(discharge_drive),
        .resetting(resetting));
    lri_host host_i (.pclk(pclk), .clear_req(clear_req),
        .discharge_drive(discharge_drive), .hardware_clear_input_n(pin_n),
        .ext_supply_on(ext_on));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] soft_val(input int i, logic [31:0] d);
        // Soft reset keeps on, inverse, segment, save, all-lit, power, bias.
        case (i)
            0: return d & 32'h67;
            1: return (d & 32'hF) | 32'h1000;
            2: return d & 32'h1;
            default: return 32'h0;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    task automatic hw_reset;
        clear_req <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(32'({display_on, display_inverse, segment_reverse, power_control,
            bias_seventh, oscillator_run, discharge_drive, resetting}),
            32'h3);
        chk(32'(ext_on), 32'h0);
        clear_req <= 1'b0;
        @(posedge pclk);
        while (resetting !== 1'b0) @(posedge pclk);
        // Status idle value: segment normal and display off read as ones.
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h60);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'(lri_pkg::CONTRAST_RST) << 7);
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        rd(8'h18, 32'h0);
        $display("test pin reset done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        clear_req = 1'b1;
        rnd = 32'h0001_2350;
        {mismatches, check_count, cyc} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        hw_reset();
        xfer(1'b0, 8'h1C, 32'h0);
        chk(32'(e), 32'h1);
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 4; i++) begin
                rnd = lfsr(rnd);
                wv[i] = rnd & rm[i];
                xfer(1'b1, ra[i], wv[i]);
            end
            for (int i = 0; i < 4; i++) rd(ra[i], wv[i]);
            chk(32'({display_on, display_inverse, segment_reverse,
                     power_control, bias_seventh, oscillator_run}),
                32'({wv[0][0], wv[0][1], wv[0][2], wv[1][2:0], wv[2][0],
                     wv[1][3]}));
            xfer(1'b1, 8'h00, 32'h1);
            xfer(1'b1, 8'h08, ~wv[0]);
            chk(32'(e), 32'h1);
            rd(8'h04, 32'h90 | 32'({~wv[0][2], ~wv[0][0]}) << 5);
            while (resetting !== 1'b0) @(posedge pclk);
            for (int i = 0; i < 4; i++) rd(ra[i], soft_val(i, wv[i]));
            $display("test soft reset round %0d done", k);
        end
        xfer(1'b1, 8'h18, 32'h1);
        xfer(1'b1, 8'h18, 32'h1);
        rd(8'h18, 32'h0000_0203);
        // Supply shutdown: power save first, then the supply stages off.
        xfer(1'b1, 8'h08, 32'h20);
        xfer(1'b1, 8'h0C, 32'h0);
        hw_reset();
        conclude();
    end
endmodule
`default_nettype wire
